// ==== verif/cbx_core_tb.sv ====
// cbx_core_tb: command sequences against the core with expected results.
// assumes cbx_mem_model answers on the far side; registers read via debug port.
module cbx_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk_i = 1'b0;
	logic              reset_i = 1'b1;
	logic              cmd_valid_i = 1'b0;
	cbx_pkg::cbx_op_t  cmd_op_i = cbx_pkg::OP_NOP;
	logic [4:0]        cmd_rd_i = 5'h00;
	logic [4:0]        cmd_rr_i = 5'h00;
	logic [2:0]        cmd_bit_i = 3'h0;
	logic [1:0]        cmd_ptr_i = 2'h0;
	logic [1:0]        cmd_mode_i = 2'h0;
	logic [15:0]       cmd_k_i = 16'h0000;
	logic [4:0]        dbg_sel_i = 5'h00;
	logic              cmd_ready_o, dm_we_o, dm_re_o, io_we_o, io_re_o, pm_re_o, pm_we_o;
	logic              pm_done_i, sleep_o, watchdog_restart_o, break_o;
	logic [15:0]       dm_addr_o, pm_addr_o, pm_wdata_o, pc_o;
	logic [7:0]        dm_wdata_o, dm_rdata_i, io_wdata_o, io_rdata_i, pm_rdata_i;
	logic [7:0]        status_register_o, dbg_data_o, sr = 8'h00;
	logic [5:0]        io_addr_o;
	logic [2:0]        pulse;
	logic [15:0]       exp_pc = 16'h0000;
	int                n_fail = 0;
	int                check_count = 0;
	int                cyc = 0;

	cbx_core cbx_core_i (.clk_i, .reset_i, .cmd_valid_i, .cmd_op_i, .cmd_rd_i, .cmd_rr_i,
		.cmd_bit_i, .cmd_ptr_i, .cmd_mode_i, .cmd_k_i, .cmd_ready_o, .dm_addr_o, .dm_wdata_o,
		.dm_we_o, .dm_re_o, .dm_rdata_i, .io_addr_o, .io_wdata_o, .io_we_o, .io_re_o,
		.io_rdata_i, .pm_addr_o, .pm_re_o, .pm_rdata_i, .pm_we_o, .pm_wdata_o, .pm_done_i,
		.sleep_o, .watchdog_restart_o, .break_o, .pc_o, .status_register_o, .dbg_sel_i,
		.dbg_data_o);
	cbx_mem_model cbx_mem_model_i (.clk_i, .dm_addr_i(dm_addr_o), .dm_wdata_i(dm_wdata_o),
		.dm_we_i(dm_we_o), .dm_re_i(dm_re_o), .dm_rdata_o(dm_rdata_i), .io_addr_i(io_addr_o),
		.io_wdata_i(io_wdata_o), .io_we_i(io_we_o), .io_re_i(io_re_o),
		.io_rdata_o(io_rdata_i), .pm_addr_i(pm_addr_o), .pm_re_i(pm_re_o),
		.pm_we_i(pm_we_o), .pm_wdata_i(pm_wdata_o), .pm_rdata_o(pm_rdata_i),
		.pm_done_o(pm_done_i));

	always #5 clk_i = ~clk_i;

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// keep=1 leaves valid high so the next call follows with no gap
	task automatic cmd(input cbx_pkg::cbx_op_t op, input logic [4:0] rd = 5'h00,
		input logic [4:0] rr = 5'h00, input logic [2:0] b = 3'h0, input logic [1:0] p = 2'h0,
		input logic [1:0] m = 2'h0, input logic [15:0] k = 16'h0000, input bit keep = 1'b0);
		int i;
		cmd_valid_i <= 1'b1;
		cmd_op_i <= op;
		cmd_rd_i <= rd;
		cmd_rr_i <= rr;
		cmd_bit_i <= b;
		cmd_ptr_i <= p;
		cmd_mode_i <= m;
		cmd_k_i <= k;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (cmd_ready_o !== 1'b1 && i < 9000);
		exp_pc += (op == cbx_pkg::OP_LOAD_DIRECT || op == cbx_pkg::OP_WRITE_DIRECT) ? 2 : 1;
		if (!keep) begin
			cmd_valid_i <= 1'b0;
			cyc = 0;
			do begin
				@(posedge clk_i);
				cyc++;
				if (cyc == 1) pulse = {sleep_o, watchdog_restart_o, break_o};
			end while (cmd_ready_o !== 1'b1 && cyc < 9000);
		end
		if (i >= 9000 || cyc >= 9000) begin
			n_fail++;
			$display("[FAIL] %0t core never ready", $time);
			test_done();
		end
	endtask : cmd

	task automatic creg(input logic [4:0] r, input logic [7:0] exp);
		dbg_sel_i <= r;
		@(posedge clk_i);
		@(posedge clk_i);
		chk(dbg_data_o, exp, "register");
	endtask : creg

	task automatic ldc(input logic [4:0] r, input logic [7:0] k, input bit keep = 1'b0);
		cmd(cbx_pkg::OP_LOAD_CONSTANT, r, 5'h00, 3'h0, 2'h0, 2'h0, {8'h00, k}, keep);
	endtask : ldc

	task automatic br(input cbx_pkg::cbx_op_t op, input logic [6:0] k, input bit taken);
		cmd(op, 5'h00, 5'h00, 3'h0, 2'h0, 2'h0, {9'h000, k});
		if (taken) exp_pc += {{9{k[6]}}, k};
		chk(pc_o, exp_pc, "branch pc");
		chk(cyc[15:0], taken ? 16'h0002 : 16'h0001, "branch cycles");
	endtask : br

	// returns {carry, result}
	function automatic logic [8:0] ref_op(input cbx_pkg::cbx_op_t op, input logic [7:0] a,
		input logic c);
		case (op)
			cbx_pkg::OP_SHIFT_LEFT_LOGICAL: return {a, 1'b0};
			cbx_pkg::OP_SHIFT_RIGHT_LOGICAL: return {a[0], 1'b0, a[7:1]};
			cbx_pkg::OP_ROTATE_LEFT_VIA_CARRY: return {a, c};
			cbx_pkg::OP_ROTATE_RIGHT_VIA_CARRY: return {a[0], c, a[7:1]};
			cbx_pkg::OP_SHIFT_RIGHT_ARITHMETIC: return {a[0], a[7], a[7:1]};
			default: return {c, a[3:0], a[7:4]};
		endcase
	endfunction : ref_op

	initial begin
		cbx_pkg::cbx_op_t sh [6];
		cbx_pkg::cbx_op_t ctl [4];
		logic [8:0] r;
		logic [7:0] v;
		logic [7:0] a;
		logic [7:0] lo;
		logic [4:0] pr;
		sh = '{cbx_pkg::OP_SHIFT_LEFT_LOGICAL, cbx_pkg::OP_SHIFT_RIGHT_LOGICAL,
			cbx_pkg::OP_ROTATE_LEFT_VIA_CARRY, cbx_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
			cbx_pkg::OP_SHIFT_RIGHT_ARITHMETIC, cbx_pkg::OP_NIBBLE_SWAP};
		ctl = '{cbx_pkg::OP_NOP, cbx_pkg::OP_SLEEP, cbx_pkg::OP_WATCHDOG_RESTART,
			cbx_pkg::OP_DEBUG_BREAK};
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		chk(pc_o, 16'h0000, "reset pc");
		chk(status_register_o, 8'h00, "reset status");
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			cmd(i < 8 ? cbx_pkg::OP_STATUS_BIT_SET : cbx_pkg::OP_STATUS_BIT_CLEAR, 5'h00, 5'h00,
				i[2:0]);
			sr[i[2:0]] = (i < 8);
			chk(status_register_o, sr, "status bit");
			chk(cyc[15:0], 16'h0001, "status cycles");
		end
		$display("status flag test done");
		for (int j = 0; j < 12; j++) begin
			a = j[0] ? 8'h01 : 8'h81;
			ldc(5'h10, a);
			cmd(j[0] ? cbx_pkg::OP_STATUS_BIT_CLEAR : cbx_pkg::OP_STATUS_BIT_SET, 5'h00, 5'h00,
				cbx_pkg::SR_C);
			sr[cbx_pkg::SR_C] = ~j[0];
			cmd(sh[j / 2], 5'h10);
			chk(cyc[15:0], 16'h0001, "shift cycles");
			r = ref_op(sh[j / 2], a, ~j[0]);
			if (sh[j / 2] != cbx_pkg::OP_NIBBLE_SWAP) begin
				sr[cbx_pkg::SR_C] = r[8];
				sr[cbx_pkg::SR_Z] = (r[7:0] == 8'h00);
				sr[cbx_pkg::SR_N] = r[7];
				sr[cbx_pkg::SR_V] = r[7] ^ r[8];
			end
			chk(status_register_o, sr, "shift flags");
			creg(5'h10, r[7:0]);
		end
		$display("shift test done");
		ldc(5'h10, 8'h80);
		cmd(cbx_pkg::OP_TRANSFER_FLAG_STORE, 5'h00, 5'h10, 3'h7);
		sr[cbx_pkg::SR_T] = 1'b1;
		chk(status_register_o, sr, "transfer store");
		ldc(5'h11, 8'h00);
		cmd(cbx_pkg::OP_TRANSFER_FLAG_LOAD, 5'h11, 5'h00, 3'h2);
		chk(cyc[15:0], 16'h0001, "transfer cycles");
		creg(5'h11, 8'h04);
		cmd(cbx_pkg::OP_STATUS_BIT_SET, 5'h00, 5'h00, cbx_pkg::SR_I);
		sr[cbx_pkg::SR_I] = 1'b1;
		br(cbx_pkg::OP_BRANCH_ON_IRQ_ENABLED, 7'h05, 1'b1);
		br(cbx_pkg::OP_BRANCH_ON_IRQ_DISABLED, 7'h7D, 1'b0);
		cmd(cbx_pkg::OP_STATUS_BIT_CLEAR, 5'h00, 5'h00, cbx_pkg::SR_I);
		sr[cbx_pkg::SR_I] = 1'b0;
		br(cbx_pkg::OP_BRANCH_ON_IRQ_DISABLED, 7'h7D, 1'b1);
		br(cbx_pkg::OP_BRANCH_ON_IRQ_ENABLED, 7'h05, 1'b0);
		$display("branch test done");
		ldc(5'h12, 8'h3C);
		cmd(cbx_pkg::OP_IO_WRITE, 5'h00, 5'h12, 3'h0, 2'h0, 2'h0, 16'h0005);
		cmd(cbx_pkg::OP_IO_BIT_SET, 5'h00, 5'h00, 3'h7, 2'h0, 2'h0, 16'h0005);
		chk(cyc[15:0], 16'h0002, "io set cycles");
		cmd(cbx_pkg::OP_IO_BIT_CLEAR, 5'h00, 5'h00, 3'h2, 2'h0, 2'h0, 16'h0005);
		chk(cyc[15:0], 16'h0002, "io clear cycles");
		cmd(cbx_pkg::OP_IO_READ, 5'h13, 5'h00, 3'h0, 2'h0, 2'h0, 16'h0005);
		creg(5'h13, 8'hB8);
		chk(status_register_o, sr, "io flags");
		$display("io test done");
		for (int p = 0; p < 3; p++) begin
			for (int m = 0; m < 3; m++) begin
				pr = cbx_pkg::PTR_BASE + 5'(2 * p);
				v = 8'hA0 + 8'(4 * p + m);
				lo = (m == 0) ? 8'h80 : (m == 1) ? 8'h81 : 8'h7F;
				ldc(pr, 8'h80);
				ldc(pr + 5'h01, 8'h01 + 8'(p));
				ldc(5'h14, v);
				cmd(cbx_pkg::OP_WRITE_VIA_POINTER, 5'h00, 5'h14, 3'h0, p[1:0], m[1:0], 16'h0000);
				chk(cyc[15:0], 16'h0002, "store cycles");
				chk(cbx_mem_model_i.dm[{8'h01 + 8'(p), m == 2 ? 8'h7F : 8'h80}], v, "store");
				creg(pr, lo);
				ldc(pr, 8'h80);
				cmd(cbx_pkg::OP_LOAD_VIA_POINTER, 5'h15, 5'h00, 3'h0, p[1:0], m[1:0], 16'h0000);
				chk(cyc[15:0], 16'h0002, "load cycles");
				creg(5'h15, v);
				creg(pr, lo);
			end
		end
		for (int p = 1; p < 3; p++) begin
			pr = cbx_pkg::PTR_BASE + 5'(2 * p);
			ldc(pr, 8'h40);
			ldc(pr + 5'h01, 8'h02);
			ldc(5'h14, 8'hC0 + 8'(p));
			cmd(cbx_pkg::OP_WRITE_WITH_OFFSET, 5'h00, 5'h14, 3'h0, p[1:0], 2'h0, 16'h003F);
			chk(cyc[15:0], 16'h0002, "offset store cycles");
			chk(cbx_mem_model_i.dm[16'h027F], 8'hC0 + 8'(p), "offset store");
			cmd(cbx_pkg::OP_LOAD_WITH_OFFSET, 5'h16, 5'h00, 3'h0, p[1:0], 2'h0, 16'h003F);
			chk(cyc[15:0], 16'h0002, "offset load cycles");
			creg(5'h16, 8'hC0 + 8'(p));
			creg(pr, 8'h40);
		end
		ldc(5'h14, 8'h5A);
		cmd(cbx_pkg::OP_WRITE_DIRECT, 5'h00, 5'h14);
		chk(cyc[15:0], 16'h0002, "direct store cycles");
		cmd(cbx_pkg::OP_LOAD_DIRECT, 5'h17);
		chk(cyc[15:0], 16'h0002, "direct load cycles");
		creg(5'h17, 8'h5A);
		chk(pc_o, exp_pc, "direct pc");
		cmd(cbx_pkg::OP_STACK_PULL, 5'h18);
		chk(cyc[15:0], 16'h0002, "pull cycles");
		creg(5'h18, 8'h5A);
		chk(status_register_o, sr, "memory flags");
		$display("memory test done");
		ldc(5'h1E, 8'h23);
		ldc(5'h1F, 8'h01);
		cmd(cbx_pkg::OP_PROGRAM_MEMORY_READ, 5'h05, 5'h00, 3'h0, 2'h0, cbx_pkg::MODE_IMPLIED,
			16'h0000);
		chk(cyc[15:0], 16'h0003, "pm read cycles");
		creg(cbx_pkg::REG_ZERO, 8'h23 ^ 8'h01 ^ 8'h96);
		cmd(cbx_pkg::OP_PROGRAM_MEMORY_READ, 5'h19, 5'h00, 3'h0, 2'h0, cbx_pkg::MODE_POSTINC,
			16'h0000);
		chk(cyc[15:0], 16'h0003, "pm read cycles");
		creg(5'h19, 8'h23 ^ 8'h01 ^ 8'h96);
		creg(5'h1E, 8'h24);
		ldc(cbx_pkg::REG_ZERO, 8'h34);
		ldc(cbx_pkg::REG_ONE, 8'h12);
		cmd(cbx_pkg::OP_PROGRAM_MEMORY_WRITE);
		chk(cbx_mem_model_i.pm_wr_data_q, 16'h1234, "pm write data");
		chk(cbx_mem_model_i.pm_wr_addr_q, 16'h0124, "pm write address");
		$display("program memory test done");
		for (int i = 0; i < 4; i++) begin
			cmd(ctl[i]);
			chk(cyc[15:0], 16'h0001, "control cycles");
			chk(pulse, i == 0 ? 3'h0 : 3'h1 << (3 - i), "control pulse");
		end
		ldc(5'h02, 8'h11, 1'b1);
		ldc(5'h03, 8'h22);
		creg(5'h02, 8'h11);
		creg(5'h03, 8'h22);
		chk(pc_o, exp_pc, "final pc");
		$display("control test done");
		test_done();
	end
endmodule : cbx_core_tb

// ==== verif/cbx_mem_model.sv ====
// cbx_mem_model: data memory, I/O space and program memory facing the core.
// assumes the core's strobes are one-cycle register pulses on clk_i.
module cbx_mem_model #(
	parameter int PM_LAT = 4
) (
	// clock
	input  wire logic        clk_i,
	// data memory
	input  wire logic [15:0] dm_addr_i,
	input  wire logic [7:0]  dm_wdata_i,
	input  wire logic        dm_we_i,
	input  wire logic        dm_re_i,
	output logic      [7:0]  dm_rdata_o,
	// I/O space
	input  wire logic [5:0]  io_addr_i,
	input  wire logic [7:0]  io_wdata_i,
	input  wire logic        io_we_i,
	input  wire logic        io_re_i,
	output logic      [7:0]  io_rdata_o,
	// program memory
	input  wire logic [15:0] pm_addr_i,
	input  wire logic        pm_re_i,
	input  wire logic        pm_we_i,
	input  wire logic [15:0] pm_wdata_i,
	output logic      [7:0]  pm_rdata_o = 8'h00,
	output logic             pm_done_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  dm [0:65535];
	logic [7:0]  io [0:63];
	logic [7:0]  junk_q = 8'h5C;
	logic [15:0] pm_wr_addr_q = 16'h0000;
	logic [15:0] pm_wr_data_q = 16'h0000;
	int          pm_cnt_q = 0;
	// idle buses carry a moving pattern so stale data never looks valid
	assign dm_rdata_o = dm_re_i ? dm[dm_addr_i] : junk_q;
	assign io_rdata_o = io_re_i ? io[io_addr_i] : ~junk_q;
	always @(posedge clk_i) begin
		junk_q <= junk_q + 8'h3B;
		if (dm_we_i) dm[dm_addr_i] <= dm_wdata_i;
		if (io_we_i) io[io_addr_i] <= io_wdata_i;
		pm_rdata_o <= pm_re_i ? (pm_addr_i[7:0] ^ pm_addr_i[15:8] ^ 8'h96) : ~junk_q;
		pm_done_o <= (pm_cnt_q == 1);
		if (pm_we_i) begin
			pm_wr_addr_q <= pm_addr_i;
			pm_wr_data_q <= pm_wdata_i;
			pm_cnt_q <= PM_LAT;
		end else if (pm_cnt_q != 0) begin
			pm_cnt_q <= pm_cnt_q - 1;
		end
	end
endmodule : cbx_mem_model

// ==== verilog/cbx_core.sv ====
// cbx_core: executes interrupt-flag branches, bit ops, shifts, flag ops,
// loads, stores, program memory access and control commands.
// assumes data and I/O memories answer with their read strobe and
// program memory one cycle after its read strobe.
//
// How it works
// RL1: interrupt-flag branches: add offset plus one, 1/2 cycles
// RL2: I/O bit set/clear, two cycles, no flags
// RL3: logical shifts insert zero, update Z C N V
// RL4: rotates through carry, update Z C N V
// RL5: arithmetic right shift keeps sign bit
// RL6: nibble swap, one cycle, flags untouched
// RL7: set/clear any status bit, one cycle
// RL8: overflow flag set/clear, one cycle
// RL9: transfer flag store and load, one cycle
// RL10: pointer loads, two cycles, post-inc or pre-dec
// RL11: pointer stores, two cycles, post-inc or pre-dec
// RL12: displaced load from Y/Z plus q, two cycles
// RL13: displaced store to Y/Z plus q, two cycles
// RL14: direct load/store, two cycles, no flags
// RL15: program memory read via Z, three cycles
// RL16: stack pull into register, two cycles
// RL17: nop, sleep, watchdog restart take one cycle
// RL18: break only signals the debug system
// RL19: moves, constants, I/O transfers in one cycle
// RL20: program memory write of R1:R0 at Z
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module cbx_core (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// command port
	input  wire logic             cmd_valid_i,
	input  wire cbx_pkg::cbx_op_t cmd_op_i,
	input  wire logic [4:0]       cmd_rd_i,
	input  wire logic [4:0]       cmd_rr_i,
	input  wire logic [2:0]       cmd_bit_i,
	input  wire logic [1:0]       cmd_ptr_i,
	input  wire logic [1:0]       cmd_mode_i,
	input  wire logic [15:0]      cmd_k_i,
	output logic                  cmd_ready_o,
	// data memory
	output logic [15:0]           dm_addr_o,
	output logic [7:0]            dm_wdata_o,
	output logic                  dm_we_o,
	output logic                  dm_re_o,
	input  wire logic [7:0]       dm_rdata_i,
	// I/O space
	output logic [5:0]            io_addr_o,
	output logic [7:0]            io_wdata_o,
	output logic                  io_we_o,
	output logic                  io_re_o,
	input  wire logic [7:0]       io_rdata_i,
	// program memory
	output logic [15:0]           pm_addr_o,
	output logic                  pm_re_o,
	input  wire logic [7:0]       pm_rdata_i,
	output logic                  pm_we_o,
	output logic [15:0]           pm_wdata_o,
	input  wire logic             pm_done_i,
	// control pulses and state
	output logic                  sleep_o,
	output logic                  watchdog_restart_o,
	output logic                  break_o,
	output logic [15:0]           pc_o,
	output logic [7:0]            status_register_o,
	input  wire logic [4:0]       dbg_sel_i,
	output logic [7:0]            dbg_data_o
);

	cbx_pkg::cbx_state_t state_q, state_d;
	logic [7:0]  rf_q [32];
	logic [7:0]  status_register_q, status_register_d;
	logic [15:0] pc_q, sp_q;
	logic        ready_q;
	logic        in_pend_q, bit_set_q;
	logic [4:0]  in_idx_q, dst_q;
	logic [2:0]  bit_q;
	logic [15:0] dm_addr_q, pm_addr_q, pm_wdata_q;
	logic [7:0]  dm_wdata_q, io_wdata_q, dbg_q;
	logic [5:0]  io_addr_q;
	logic        dm_we_q, dm_re_q, io_we_q, io_re_q, pm_re_q, pm_we_q;
	logic        sleep_q, wdr_q, brk_q;
	logic [7:0]  sh_res, wr_val;
	logic        sh_c, wr_en;
	logic [15:0] ea;

	// register view with a pending I/O read forwarded in
	wire [7:0] rv [32];
	for (genvar g = 0; g < 32; g++) begin : g_fwd
		assign rv[g] = (in_pend_q && in_idx_q == 5'(g)) ? io_rdata_i : rf_q[g];
	end

	wire acc    = cmd_valid_i && ready_q;
	wire is_bre = cmd_op_i == cbx_pkg::OP_BRANCH_ON_IRQ_ENABLED;
	wire is_brd = cmd_op_i == cbx_pkg::OP_BRANCH_ON_IRQ_DISABLED;
	wire is_ios = cmd_op_i == cbx_pkg::OP_IO_BIT_SET;
	wire is_ioc = cmd_op_i == cbx_pkg::OP_IO_BIT_CLEAR;
	wire is_shl = cmd_op_i == cbx_pkg::OP_SHIFT_LEFT_LOGICAL;
	wire is_shr = cmd_op_i == cbx_pkg::OP_SHIFT_RIGHT_LOGICAL;
	wire is_rl  = cmd_op_i == cbx_pkg::OP_ROTATE_LEFT_VIA_CARRY;
	wire is_rr  = cmd_op_i == cbx_pkg::OP_ROTATE_RIGHT_VIA_CARRY;
	wire is_sra = cmd_op_i == cbx_pkg::OP_SHIFT_RIGHT_ARITHMETIC;
	wire is_swp = cmd_op_i == cbx_pkg::OP_NIBBLE_SWAP;
	wire is_sbs = cmd_op_i == cbx_pkg::OP_STATUS_BIT_SET;
	wire is_sbc = cmd_op_i == cbx_pkg::OP_STATUS_BIT_CLEAR;
	wire is_tst = cmd_op_i == cbx_pkg::OP_TRANSFER_FLAG_STORE;
	wire is_tld = cmd_op_i == cbx_pkg::OP_TRANSFER_FLAG_LOAD;
	wire is_mov = cmd_op_i == cbx_pkg::OP_MOVE;
	wire is_pcp = cmd_op_i == cbx_pkg::OP_REGISTER_PAIR_COPY;
	wire is_ldk = cmd_op_i == cbx_pkg::OP_LOAD_CONSTANT;
	wire is_lvp = cmd_op_i == cbx_pkg::OP_LOAD_VIA_POINTER;
	wire is_lwo = cmd_op_i == cbx_pkg::OP_LOAD_WITH_OFFSET;
	wire is_ldr = cmd_op_i == cbx_pkg::OP_LOAD_DIRECT;
	wire is_wvp = cmd_op_i == cbx_pkg::OP_WRITE_VIA_POINTER;
	wire is_wwo = cmd_op_i == cbx_pkg::OP_WRITE_WITH_OFFSET;
	wire is_wdr = cmd_op_i == cbx_pkg::OP_WRITE_DIRECT;
	wire is_pmr = cmd_op_i == cbx_pkg::OP_PROGRAM_MEMORY_READ;
	wire is_pmw = cmd_op_i == cbx_pkg::OP_PROGRAM_MEMORY_WRITE;
	wire is_ior = cmd_op_i == cbx_pkg::OP_IO_READ;
	wire is_iow = cmd_op_i == cbx_pkg::OP_IO_WRITE;
	wire is_pop = cmd_op_i == cbx_pkg::OP_STACK_PULL;

	wire is_shift = is_shl || is_shr || is_rl || is_rr || is_sra;
	wire is_iobit = is_ios || is_ioc;
	wire is_load  = is_lvp || is_lwo || is_ldr || is_pop;
	wire is_store = is_wvp || is_wwo || is_wdr;
	wire irq_on   = status_register_q[cbx_pkg::SR_I];
	wire taken    = (is_bre && irq_on) || (is_brd && !irq_on); // RL1
	wire [7:0] opa  = rv[cmd_rd_i];
	wire [7:0] opb  = rv[cmd_rr_i];
	wire [7:0] mask = 8'h01 << cmd_bit_i;

	// program memory always goes through Z
	wire [1:0]  psel   = (is_pmr || is_pmw) ? cbx_pkg::PTR_Z : cmd_ptr_i;
	wire [4:0]  pidx   = cbx_pkg::PTR_BASE + {2'b00, psel, 1'b0};
	wire [4:0]  pidx_h = {pidx[4:1], 1'b1};
	wire [15:0] ptr_w  = {rv[pidx_h], rv[pidx]};
	wire        predec = cmd_mode_i == cbx_pkg::MODE_PREDEC;
	wire        postin = cmd_mode_i == cbx_pkg::MODE_POSTINC;
	wire [15:0] ptr_new = predec ? ptr_w - 16'h0001 : ptr_w + 16'h0001;
	wire        ptr_upd = ((is_lvp || is_wvp) && (predec || postin)) // RL10 RL11
		|| (is_pmr && postin); // RL15
	wire [15:0] disp   = {10'h000, cmd_k_i[cbx_pkg::DISP_MSB:0]};
	wire [15:0] sp_p1  = sp_q + 16'h0001;
	wire [15:0] br_ofs = {{9{cmd_k_i[cbx_pkg::BR_OFS_MSB]}}, cmd_k_i[6:0]};
	wire [4:0]  pm_dst = (cmd_mode_i == cbx_pkg::MODE_IMPLIED) ? cbx_pkg::REG_ZERO : cmd_rd_i;

	// effective data address
	always_comb begin
		ea = ptr_w;
		if ((is_lvp || is_wvp) && predec)
			ea = ptr_new; // RL10 RL11
		else if (is_lwo || is_wwo)
			ea = ptr_w + disp; // RL12 RL13
		else if (is_ldr || is_wdr)
			ea = cmd_k_i; // RL14
		else if (is_pop)
			ea = sp_p1; // RL16
	end

	// shift and rotate unit
	always_comb begin
		sh_res = opa;
		sh_c   = status_register_q[cbx_pkg::SR_C];
		if (is_shl) begin
			sh_res = {opa[6:0], 1'b0}; // RL3
			sh_c   = opa[7];
		end else if (is_shr) begin
			sh_res = {1'b0, opa[7:1]}; // RL3
			sh_c   = opa[0];
		end else if (is_rl) begin
			sh_res = {opa[6:0], status_register_q[cbx_pkg::SR_C]}; // RL4
			sh_c   = opa[7];
		end else if (is_rr) begin
			sh_res = {status_register_q[cbx_pkg::SR_C], opa[7:1]}; // RL4
			sh_c   = opa[0];
		end else if (is_sra) begin
			sh_res = {opa[7], opa[7:1]}; // RL5
			sh_c   = opa[0];
		end
	end

	// single-cycle register writeback
	always_comb begin
		wr_en  = 1'b1;
		wr_val = sh_res;
		if (is_shift)
			wr_val = sh_res;
		else if (is_swp)
			wr_val = {opa[3:0], opa[7:4]}; // RL6
		else if (is_tld)
			wr_val = status_register_q[cbx_pkg::SR_T] ? (opa | mask) : (opa & ~mask); // RL9
		else if (is_mov)
			wr_val = opb; // RL19
		else if (is_ldk)
			wr_val = cmd_k_i[7:0]; // RL19
		else
			wr_en = 1'b0;
	end

	// status register next value; everything else leaves it alone
	always_comb begin
		status_register_d = status_register_q;
		if (is_shift) begin
			status_register_d[cbx_pkg::SR_C] = sh_c; // RL3 RL4 RL5
			status_register_d[cbx_pkg::SR_Z] = sh_res == 8'h00;
			status_register_d[cbx_pkg::SR_N] = sh_res[7];
			status_register_d[cbx_pkg::SR_V] = sh_res[7] ^ sh_c;
		end else if (is_sbs) begin
			status_register_d[cmd_bit_i] = 1'b1; // RL7 RL8
		end else if (is_sbc) begin
			status_register_d[cmd_bit_i] = 1'b0; // RL7 RL8
		end else if (is_tst) begin
			status_register_d[cbx_pkg::SR_T] = opb[cmd_bit_i]; // RL9
		end
	end

	wire [15:0] pc_step = (is_ldr || is_wdr) ? cbx_pkg::PC_STEP_LONG : cbx_pkg::PC_STEP;
	wire [15:0] pc_d = taken ? pc_q + br_ofs + cbx_pkg::PC_STEP : pc_q + pc_step; // RL1

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			cbx_pkg::S_RUN: begin
				if (acc && (taken || is_iobit || is_load || is_store))
					state_d = cbx_pkg::S_WAIT; // RL1 RL2 RL10 RL11 RL16
				else if (acc && is_pmr)
					state_d = cbx_pkg::S_PM1; // RL15
				else if (acc && is_pmw)
					state_d = cbx_pkg::S_PMW; // RL20
			end
			cbx_pkg::S_WAIT: state_d = cbx_pkg::S_RUN;
			cbx_pkg::S_PM1:  state_d = cbx_pkg::S_PM2;
			cbx_pkg::S_PM2:  state_d = cbx_pkg::S_RUN;
			cbx_pkg::S_PMW: begin
				if (pm_done_i)
					state_d = cbx_pkg::S_RUN; // RL20
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q <= cbx_pkg::S_RUN;
			ready_q <= 1'b1;
			pc_q    <= cbx_pkg::PC_RESET;
			status_register_q  <= cbx_pkg::SR_RESET;
			sp_q    <= cbx_pkg::SP_RESET;
		end else begin
			state_q <= state_d;
			ready_q <= state_d == cbx_pkg::S_RUN;
			if (acc) begin
				pc_q   <= pc_d;
				status_register_q <= status_register_d;
			end
			if (acc && is_pop)
				sp_q <= sp_p1; // RL16
		end
	end

	// later lines win; ready stays low while a memory capture is pending, not while an I/O read capture is
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < 32; i++)
				rf_q[i] <= 8'h00;
		end else begin
			if (in_pend_q)
				rf_q[in_idx_q] <= io_rdata_i; // RL19
			if (dm_re_q)
				rf_q[dst_q] <= dm_rdata_i; // RL10 RL12 RL14 RL16
			if (state_q == cbx_pkg::S_PM2)
				rf_q[dst_q] <= pm_rdata_i; // RL15
			if (acc && wr_en)
				rf_q[cmd_rd_i] <= wr_val;
			if (acc && is_pcp) begin
				rf_q[{cmd_rd_i[4:1], 1'b0}] <= rv[{cmd_rr_i[4:1], 1'b0}]; // RL19
				rf_q[{cmd_rd_i[4:1], 1'b1}] <= rv[{cmd_rr_i[4:1], 1'b1}];
			end
			if (acc && ptr_upd) begin
				rf_q[pidx]   <= ptr_new[7:0];
				rf_q[pidx_h] <= ptr_new[15:8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dm_re_q   <= 1'b0;
			dm_we_q   <= 1'b0;
			io_re_q   <= 1'b0;
			io_we_q   <= 1'b0;
			pm_re_q   <= 1'b0;
			pm_we_q   <= 1'b0;
			in_pend_q <= 1'b0;
			sleep_q   <= 1'b0;
			wdr_q     <= 1'b0;
			brk_q     <= 1'b0;
		end else begin
			dm_re_q   <= acc && is_load;
			dm_we_q   <= acc && is_store; // RL11 RL13 RL14
			io_re_q   <= acc && (is_ior || is_iobit);
			in_pend_q <= acc && is_ior;
			// a bit write follows its read one cycle later
			io_we_q   <= (acc && is_iow) || (io_re_q && !in_pend_q); // RL2
			pm_re_q   <= acc && is_pmr;
			pm_we_q   <= acc && is_pmw;
			sleep_q   <= acc && cmd_op_i == cbx_pkg::OP_SLEEP; // RL17
			wdr_q     <= acc && cmd_op_i == cbx_pkg::OP_WATCHDOG_RESTART; // RL17
			brk_q     <= acc && cmd_op_i == cbx_pkg::OP_DEBUG_BREAK; // RL18
		end
	end

	// address and data holding registers need no reset
	always_ff @(posedge clk_i) begin
		dbg_q <= rf_q[dbg_sel_i];
		if (acc) begin
			dm_addr_q  <= ea;
			dm_wdata_q <= opb;
			io_addr_q  <= cmd_k_i[cbx_pkg::IO_MSB:0];
			in_idx_q   <= cmd_rd_i;
			dst_q      <= is_pmr ? pm_dst : cmd_rd_i;
			bit_q      <= cmd_bit_i;
			bit_set_q  <= is_ios;
			pm_addr_q  <= ptr_w;
			pm_wdata_q <= {rv[cbx_pkg::REG_ONE], rv[cbx_pkg::REG_ZERO]}; // RL20
		end
		if (acc && is_iow)
			io_wdata_q <= opb;
		else if (io_re_q && !in_pend_q)
			io_wdata_q <= bit_set_q ? io_rdata_i | (8'h01 << bit_q)
				: io_rdata_i & ~(8'h01 << bit_q); // RL2
	end

	assign cmd_ready_o        = ready_q;
	assign dm_addr_o          = dm_addr_q;
	assign dm_wdata_o         = dm_wdata_q;
	assign dm_we_o            = dm_we_q;
	assign dm_re_o            = dm_re_q;
	assign io_addr_o          = io_addr_q;
	assign io_wdata_o         = io_wdata_q;
	assign io_we_o            = io_we_q;
	assign io_re_o            = io_re_q;
	assign pm_addr_o          = pm_addr_q;
	assign pm_re_o            = pm_re_q;
	assign pm_we_o            = pm_we_q;
	assign pm_wdata_o         = pm_wdata_q;
	assign sleep_o            = sleep_q;
	assign watchdog_restart_o = wdr_q;
	assign break_o            = brk_q;
	assign pc_o               = pc_q;
	assign status_register_o  = status_register_q;
	assign dbg_data_o         = dbg_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	branch_taken_a: assert property ( // RL1
		acc && taken |=> !cmd_ready_o ##1 cmd_ready_o)
		else $error("taken branch not two cycles");
	branch_fall_a: assert property ( // RL1
		acc && (is_bre || is_brd) && !taken |=> cmd_ready_o && pc_o == $past(pc_q) + 16'h0001)
		else $error("untaken branch wrong");
	io_bit_rmw_a: assert property ( // RL2
		acc && is_ios |=> io_re_o && !cmd_ready_o ##1 io_we_o && io_wdata_o[bit_q]
			&& $stable(status_register_o))
		else $error("io bit set wrong");
	shift_carry_a: assert property ( // RL3
		acc && is_shl |=> status_register_o[cbx_pkg::SR_C] == $past(opa[7])
			&& rf_q[$past(cmd_rd_i)][0] == 1'b0)
		else $error("left shift wrong");
	rotate_in_a: assert property ( // RL4
		acc && is_rl |=> rf_q[$past(cmd_rd_i)][0]
			== $past(status_register_q[cbx_pkg::SR_C]))
		else $error("rotate carry in wrong");
	swap_flags_a: assert property ( // RL6
		acc && is_swp |=> $stable(status_register_o) && cmd_ready_o)
		else $error("nibble swap touched flags");
	load_two_a: assert property ( // RL10
		acc && is_lvp |=> dm_re_o && !cmd_ready_o ##1 cmd_ready_o && !dm_re_o)
		else $error("pointer load not two cycles");
	store_data_a: assert property ( // RL11
		acc && is_store |=> dm_we_o && dm_wdata_o == $past(opb) ##1 !dm_we_o)
		else $error("store wrong");
	pm_three_a: assert property ( // RL15
		acc && is_pmr |=> pm_re_o ##1 !cmd_ready_o && !pm_re_o ##1 cmd_ready_o)
		else $error("program read not three cycles");

endmodule : cbx_core

// ==== verilog/cbx_pkg.sv ====
// cbx_pkg: command codes, status bit positions, pointer indices, reset values
// and field positions shared by the execution core and its bench.
// assumes a single core clock and a synchronous active-high reset.
package cbx_pkg;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_BRANCH_ON_IRQ_ENABLED,
		OP_BRANCH_ON_IRQ_DISABLED,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_SHIFT_LEFT_LOGICAL,
		OP_SHIFT_RIGHT_LOGICAL,
		OP_ROTATE_LEFT_VIA_CARRY,
		OP_ROTATE_RIGHT_VIA_CARRY,
		OP_SHIFT_RIGHT_ARITHMETIC,
		OP_NIBBLE_SWAP,
		OP_STATUS_BIT_SET,
		OP_STATUS_BIT_CLEAR,
		OP_TRANSFER_FLAG_STORE,
		OP_TRANSFER_FLAG_LOAD,
		OP_MOVE,
		OP_REGISTER_PAIR_COPY,
		OP_LOAD_CONSTANT,
		OP_LOAD_VIA_POINTER,
		OP_LOAD_WITH_OFFSET,
		OP_LOAD_DIRECT,
		OP_WRITE_VIA_POINTER,
		OP_WRITE_WITH_OFFSET,
		OP_WRITE_DIRECT,
		OP_PROGRAM_MEMORY_READ,
		OP_PROGRAM_MEMORY_WRITE,
		OP_IO_READ,
		OP_IO_WRITE,
		OP_STACK_PULL,
		OP_SLEEP,
		OP_WATCHDOG_RESTART,
		OP_DEBUG_BREAK
	} cbx_op_t;

	typedef enum logic [4:0] {
		S_RUN  = 5'h01,
		S_WAIT = 5'h02,
		S_PM1  = 5'h04,
		S_PM2  = 5'h08,
		S_PMW  = 5'h10
	} cbx_state_t;

	// status_register bit positions
	localparam logic [2:0] SR_C = 3'h0;
	localparam logic [2:0] SR_Z = 3'h1;
	localparam logic [2:0] SR_N = 3'h2;
	localparam logic [2:0] SR_V = 3'h3;
	localparam logic [2:0] SR_S = 3'h4;
	localparam logic [2:0] SR_H = 3'h5;
	localparam logic [2:0] SR_T = 3'h6;
	localparam logic [2:0] SR_I = 3'h7;

	// pointer select and addressing modes
	localparam logic [1:0] PTR_X        = 2'h0;
	localparam logic [1:0] PTR_Y        = 2'h1;
	localparam logic [1:0] PTR_Z        = 2'h2;
	localparam logic [4:0] PTR_BASE     = 5'h1A;
	localparam logic [4:0] REG_ZERO     = 5'h00;
	localparam logic [4:0] REG_ONE      = 5'h01;
	localparam logic [1:0] MODE_PLAIN   = 2'h0;
	localparam logic [1:0] MODE_POSTINC = 2'h1;
	localparam logic [1:0] MODE_PREDEC  = 2'h2;
	localparam logic [1:0] MODE_IMPLIED = 2'h3;

	// operand field positions inside cmd_k_i
	localparam int BR_OFS_MSB = 6;
	localparam int DISP_MSB   = 5;
	localparam int IO_MSB     = 5;

	// reset values and program counter steps
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [15:0] SP_RESET   = 16'hFFFF;
	localparam logic [7:0]  SR_RESET   = 8'h00;
	localparam logic [15:0] PC_STEP    = 16'h0001;
	localparam logic [15:0] PC_STEP_LONG = 16'h0002;

endpackage : cbx_pkg
